// *** core/srw_map.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the supervisor.
// Assumes: 250 MHz system clock; Wishbone registers one aligned word each.
// Notes:   Times kept in their own unit; cycle counts derived from them.
`ifndef SRW_MAP_SVH
`define SRW_MAP_SVH

// ----------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------
`define SRW_CLK_NS        4
`define SRW_MS_NS         1000000
`define SRW_MS_CYCLES     ((`SRW_MS_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS)
`define SRW_TRR_NS        4000
`define SRW_TRR_CYCLES    ((`SRW_TRR_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS)

// ----------------------------------------------------------------------
// Timing in milliseconds
// ----------------------------------------------------------------------
`define SRW_TXTO_MS       1000
`define SRW_TSHD_MS       128
`define SRW_HOLD_MS_DEF   8
`define SRW_HOLD_MS_OPT1  4
`define SRW_HOLD_MS_OPT2  16
`define SRW_HOLD_MS_OPT3  32
`define SRW_WD_MS_DEF     100
`define SRW_WD_MS_M40     60
`define SRW_WD_MS_M20     80
`define SRW_WD_MS_P20     120
`define SRW_WD_MS_P60     160
`define SRW_WD_MS_P100    200

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SRW_OFS_CTRL      8'h00
`define SRW_OFS_DIAG      8'h04
`define SRW_OFS_STATUS    8'h08
`define SRW_OFS_WDTRIG    8'h0c

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SRW_CTRL_TSHD     0
`define SRW_CTRL_LOWPWR   1
`define SRW_CTRL_SLEW     2
`define SRW_CTRL_TMON     3
`define SRW_CTRL_RST      8'h08
`define SRW_DIAG_WARN     0
`define SRW_DIAG_TXTO     1
`define SRW_DIAG_WD       2

`endif

// *** core/srw_pkg.sv ***
// Purpose: Types shared by the supervisor and its bench.
// Assumes: Constants live in srw_map.svh.
// Notes:   All state of the top is one packed struct.
package srw_pkg;

  // ----------------------------------------------------------------------
  // Modes and watchdog phases
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {M_OFF, M_NORMAL, M_LOWPWR, M_TEMPSHD, M_THERM} srw_mode_t;
  typedef enum logic [1:0] {WD_OFF, WD_CLOSED, WD_OPEN, WD_FIRE} srw_wd_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } srw_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } srw_wb_rsp_t;

  typedef struct packed {
    logic       wd_enable;
    logic [2:0] wd_window;
    logic [1:0] hold_sel;
    logic [1:0] uv_sel;
  } srw_otp_t;

  typedef struct packed {
    logic [17:0] tick_cnt;
    logic        tick;
    logic        por_n;
    srw_mode_t   mode;
    srw_otp_t    otp;
    logic        ctl_tshd;
    logic        ctl_lowpwr;
    logic        ctl_slew;
    logic        ctl_tmon;
    logic        diag_warn;
    logic        diag_txto;
    logic        diag_wd;
    logic        rail_n;
    logic [9:0]  rail_cnt;
    srw_wd_t     wd;
    logic [9:0]  wd_cnt;
    logic [9:0]  tx_cnt;
    logic        tx_to;
    logic [7:0]  shd_cnt;
    logic        rst_out_n;
    logic        ack;
    logic [7:0]  rdat;
    logic        reg_en;
    logic        reg_lp;
    logic        xcvr_en;
    logic        slew_en;
    logic        lin_dom;
  } srw_state_t;

endpackage : srw_pkg

// *** core/srw_top.sv ***
// Purpose: Supply and rail reset, window watchdog, transmit timeout, thermal handling.
// Assumes: Comparator and strap inputs are synchronous to clk; Wishbone classic slave.
// Notes:   Register writes stand in for the two-wire port.
// Operation
// R1 - Above shutdown temperature power down; on return power up and reset.
// R2 - Warning level sets a diagnostic flag readable by software.
// R3 - A control bit enables or disables temperature monitoring.
// R4 - Supply reset releases above release level, asserts below trip; overrides everything.
// R5 - While supply reset asserted, clear mode and diagnostics; regulator, transceiver off.
// R6 - A supply dip not crossing trip keeps the low-power mode.
// R7 - Supply reset release enters normal mode, regulator and transceiver on.
// R8 - Supply trip cancels low slew; normal mode resumes on release.
// R9 - Regulator stays off until the supply reset has risen.
// R10 - Software sets a shutdown bit; the regulator powers down.
// R11 - Reset output combines rail undervoltage reset and watchdog output.
// R12 - Shutdown and overtemperature reach the reset output only via rail reset.
// R13 - Rail reset releases after rail above release longer than hold time.
// R14 - Rail reset asserts after rail below trip longer than glitch delay.
// R15 - Rail reset initialises watchdog, timeout, port logic; control registers kept. The Wishbone port here is not reset by it.
// R16 - Rail threshold chosen by a two-bit programmed setting.
// R17 - Software triggers the watchdog; a missed window pulses reset for hold time.
// R18 - Trigger in closed interval, or none in open interval, causes reset.
// R19 - Watchdog starts after reset output high; off while rail below trip.
// R20 - Watchdog enabled by strap; three-bit strap picks window timing.
// R21 - Transmit low runs a timer; expiry releases the bus to recessive.
// R22 - Transmit timeout is about one second.
// R23 - Closed interval about 100 ms, open interval about 100 ms after it.
// R24 - Hold time 8 ms, or 4, 16, 32 ms by strap.
// R25 - Each accepted trigger restarts closed and open intervals.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`include "srw_map.svh"

module srw_top #(
  parameter int MS_CYCLES = `SRW_MS_CYCLES
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Register bus
  input  wire srw_pkg::srw_wb_req_t wb_req,
  output      srw_pkg::srw_wb_rsp_t wb_rsp,
  // Supply and rail comparators
  input  wire logic                supply_above_release,
  input  wire logic                supply_below_trip,
  input  wire logic                rail_above_release,
  input  wire logic                rail_below_trip,
  // Temperature comparators
  input  wire logic                temp_over_shutdown,
  input  wire logic                temp_below_return,
  input  wire logic                temp_over_warning,
  // Link side
  input  wire logic                tx_n,
  input  wire logic                wake_event,
  // Factory straps
  input  wire srw_pkg::srw_otp_t    otp_strap,
  // Power and reset controls
  output      logic                supply_por_n,
  output      logic                regulator_en,
  output      logic                regulator_lowpower,
  output      logic                transceiver_en,
  output      logic                low_slew_en,
  output      logic                lin_dominant,
  output      logic [1:0]          uv_thresh_sel,
  output      logic                reset_out_n
);
  import srw_pkg::*;

  srw_state_t s_reg;
  srw_state_t s_next;

  // ----------------------------------------------------------------------
  // Strap decoding
  // ----------------------------------------------------------------------
  // R24 hold time select
  function automatic logic [9:0] hold_ms(input logic [1:0] sel);
    case (sel)
      2'h1:    hold_ms = 10'(`SRW_HOLD_MS_OPT1);
      2'h2:    hold_ms = 10'(`SRW_HOLD_MS_OPT2);
      2'h3:    hold_ms = 10'(`SRW_HOLD_MS_OPT3);
      default: hold_ms = 10'(`SRW_HOLD_MS_DEF);
    endcase
  endfunction : hold_ms

  // R20 window strap scales both intervals
  function automatic logic [9:0] window_ms(input logic [2:0] sel);
    case (sel)
      3'h1:    window_ms = 10'(`SRW_WD_MS_M40);
      3'h2:    window_ms = 10'(`SRW_WD_MS_M20);
      3'h3:    window_ms = 10'(`SRW_WD_MS_P20);
      3'h4:    window_ms = 10'(`SRW_WD_MS_P60);
      3'h5:    window_ms = 10'(`SRW_WD_MS_P100);
      default: window_ms = 10'(`SRW_WD_MS_DEF);
    endcase
  endfunction : window_ms

  logic [9:0] hold_lim;
  logic [9:0] win_lim;
  logic       req;
  logic       wr;
  logic       trig;
  logic       temp_trip;

  always_comb begin
    hold_lim  = hold_ms(s_reg.otp.hold_sel);
    win_lim   = window_ms(s_reg.otp.wd_window);
    req       = wb_req.cyc & wb_req.stb;
    wr        = req & wb_req.we & s_reg.ack & wb_req.sel[0];
    trig      = wr & (wb_req.adr == `SRW_OFS_WDTRIG);
    temp_trip = s_reg.ctl_tmon & temp_over_shutdown;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // Millisecond enable; slow timers count it instead of raw cycles
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == 18'(MS_CYCLES - 1)) begin
      s_next.tick_cnt = 18'h0;
      s_next.tick     = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 18'h1;
    end

    // Bus answer one cycle after the request; write lands on the ack edge
    s_next.ack  = req & ~s_reg.ack;
    s_next.rdat = 8'h00;
    if (req & ~s_reg.ack & ~wb_req.we) begin
      case (wb_req.adr)
        `SRW_OFS_CTRL:   s_next.rdat = {4'h0, s_reg.ctl_tmon, s_reg.ctl_slew,
                                        s_reg.ctl_lowpwr, s_reg.ctl_tshd};
        `SRW_OFS_DIAG:   s_next.rdat = {5'h00, s_reg.diag_wd, s_reg.diag_txto,
                                        s_reg.diag_warn};
        `SRW_OFS_STATUS: s_next.rdat = {s_reg.wd, s_reg.por_n, s_reg.rst_out_n,
                                        s_reg.rail_n, s_reg.mode};
        default:         s_next.rdat = 8'h00;
      endcase
    end
    if (wr && wb_req.adr == `SRW_OFS_CTRL) begin
      // R10 shutdown request bit
      s_next.ctl_tshd   = wb_req.dat[`SRW_CTRL_TSHD];
      s_next.ctl_lowpwr = wb_req.dat[`SRW_CTRL_LOWPWR];
      s_next.ctl_slew   = wb_req.dat[`SRW_CTRL_SLEW];
      // R3 monitor enable
      s_next.ctl_tmon   = wb_req.dat[`SRW_CTRL_TMON];
    end
    if (wr && wb_req.adr == `SRW_OFS_DIAG) begin
      if (wb_req.dat[`SRW_DIAG_WARN]) s_next.diag_warn = 1'b0;
      if (wb_req.dat[`SRW_DIAG_TXTO]) s_next.diag_txto = 1'b0;
      if (wb_req.dat[`SRW_DIAG_WD])   s_next.diag_wd   = 1'b0;
    end

    // R4 supply reset with hysteresis
    if (!s_reg.por_n) begin
      if (supply_above_release) begin
        s_next.por_n = 1'b1;
        // R7 release enters normal mode
        s_next.mode  = M_NORMAL;
        // R16 straps caught once at release
        s_next.otp   = otp_strap;
      end
    end else if (supply_below_trip) begin
      s_next.por_n = 1'b0;
    end

    // Mode sequencing; R6 a dip above trip never reaches this point
    case (s_reg.mode)
      M_OFF: begin
        s_next.shd_cnt = 8'h00;
      end
      M_NORMAL, M_LOWPWR: begin
        if (temp_trip) begin
          // R1 shutdown temperature
          s_next.mode = M_THERM;
        end else if (s_reg.ctl_tshd) begin
          // R10 temporary shutdown
          s_next.mode    = M_TEMPSHD;
          s_next.shd_cnt = 8'h00;
        end else if (s_reg.mode == M_NORMAL && s_reg.ctl_lowpwr) begin
          s_next.mode = M_LOWPWR;
        end else if (s_reg.mode == M_LOWPWR && (wake_event || !s_reg.ctl_lowpwr)) begin
          s_next.mode       = M_NORMAL;
          s_next.ctl_lowpwr = 1'b0;
        end
      end
      M_TEMPSHD: begin
        if (temp_trip) begin
          s_next.mode = M_THERM;
        end else if (s_reg.tick) begin
          if (s_reg.shd_cnt == 8'(`SRW_TSHD_MS - 1)) begin
            s_next.mode     = M_NORMAL;
            s_next.ctl_tshd = 1'b0;
            s_next.shd_cnt  = 8'h00;
          end else begin
            s_next.shd_cnt = s_reg.shd_cnt + 8'h01;
          end
        end
      end
      M_THERM: begin
        // R1 return temperature powers back up
        if (!s_reg.ctl_tmon || temp_below_return) s_next.mode = M_NORMAL;
      end
      default: s_next.mode = M_OFF;
    endcase

    // R13 release after hold time, R14 assert after glitch delay
    if (!s_reg.rail_n) begin
      if (rail_above_release) begin
        if (s_reg.tick) begin
          if (s_reg.rail_cnt == hold_lim) begin
            s_next.rail_n   = 1'b1;
            s_next.rail_cnt = 10'h000;
          end else begin
            s_next.rail_cnt = s_reg.rail_cnt + 10'h001;
          end
        end
      end else begin
        s_next.rail_cnt = 10'h000;
      end
    end else if (rail_below_trip) begin
      if (s_reg.rail_cnt == 10'(`SRW_TRR_CYCLES)) begin
        s_next.rail_n   = 1'b0;
        s_next.rail_cnt = 10'h000;
      end else begin
        s_next.rail_cnt = s_reg.rail_cnt + 10'h001;
      end
    end else begin
      s_next.rail_cnt = 10'h000;
    end

    // R15 rail reset restarts the watchdog; R19 off below trip; R20 strap enable
    if (!s_reg.rail_n || rail_below_trip || !s_reg.otp.wd_enable) begin
      s_next.wd     = WD_OFF;
      s_next.wd_cnt = 10'h000;
    end else begin
      case (s_reg.wd)
        WD_OFF: begin
          // R19 start once reset output is high
          if (s_reg.rst_out_n) begin
            s_next.wd     = WD_CLOSED;
            s_next.wd_cnt = 10'h000;
          end
        end
        WD_CLOSED: begin
          if (trig) begin
            // R18 trigger too early
            s_next.wd      = WD_FIRE;
            s_next.wd_cnt  = 10'h000;
            s_next.diag_wd = 1'b1;
          end else if (s_reg.tick) begin
            // R23 closed interval length
            if (s_reg.wd_cnt == win_lim - 10'h001) begin
              s_next.wd     = WD_OPEN;
              s_next.wd_cnt = 10'h000;
            end else begin
              s_next.wd_cnt = s_reg.wd_cnt + 10'h001;
            end
          end
        end
        WD_OPEN: begin
          if (trig) begin
            // R25 restart from the trigger
            s_next.wd     = WD_CLOSED;
            s_next.wd_cnt = 10'h000;
          end else if (s_reg.tick) begin
            // R18 open interval ran out
            if (s_reg.wd_cnt == win_lim - 10'h001) begin
              s_next.wd      = WD_FIRE;
              s_next.wd_cnt  = 10'h000;
              s_next.diag_wd = 1'b1;
            end else begin
              s_next.wd_cnt = s_reg.wd_cnt + 10'h001;
            end
          end
        end
        WD_FIRE: begin
          // R17 reset pulse for the hold time
          if (s_reg.tick) begin
            if (s_reg.wd_cnt == hold_lim - 10'h001) begin
              s_next.wd     = WD_OFF;
              s_next.wd_cnt = 10'h000;
            end else begin
              s_next.wd_cnt = s_reg.wd_cnt + 10'h001;
            end
          end
        end
        default: s_next.wd = WD_OFF;
      endcase
    end

    // R21 dominant timer; R22 expiry count
    if (!s_reg.rail_n || s_reg.mode != M_NORMAL || tx_n) begin
      s_next.tx_cnt = 10'h000;
      s_next.tx_to  = 1'b0;
    end else if (!s_reg.tx_to && s_reg.tick) begin
      if (s_reg.tx_cnt == 10'(`SRW_TXTO_MS - 1)) begin
        s_next.tx_to     = 1'b1;
        s_next.diag_txto = 1'b1;
      end else begin
        s_next.tx_cnt = s_reg.tx_cnt + 10'h001;
      end
    end

    // R2 warning flag; set beats a same-cycle clear
    if (s_reg.ctl_tmon && temp_over_warning) s_next.diag_warn = 1'b1;

    // R5 master reset clears mode state; R8 drops low slew with it
    if (!s_next.por_n) begin
      s_next.mode       = M_OFF;
      s_next.ctl_tshd   = 1'b0;
      s_next.ctl_lowpwr = 1'b0;
      s_next.ctl_slew   = 1'b0;
      s_next.ctl_tmon   = 1'(`SRW_CTRL_RST >> `SRW_CTRL_TMON);
      s_next.diag_warn  = 1'b0;
      s_next.diag_txto  = 1'b0;
      s_next.diag_wd    = 1'b0;
      s_next.rail_n     = 1'b0;
      s_next.rail_cnt   = 10'h000;
      s_next.otp        = '0;
    end

    // R9 regulator only after supply release
    s_next.reg_en  = s_next.por_n &
                     (s_next.mode == M_NORMAL || s_next.mode == M_LOWPWR);
    s_next.reg_lp  = s_next.mode == M_LOWPWR;
    s_next.xcvr_en = s_next.mode == M_NORMAL;
    s_next.slew_en = s_next.xcvr_en & s_next.ctl_slew;
    // R21 timeout forces recessive
    s_next.lin_dom = s_next.xcvr_en & ~tx_n & ~s_next.tx_to;
    // R11 reset output; R12 shutdowns act only through the rail reset
    s_next.rst_out_n = s_next.rail_n & (s_next.wd != WD_FIRE);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign wb_rsp.ack         = s_reg.ack;
  assign wb_rsp.dat         = {24'h000000, s_reg.rdat};
  assign supply_por_n       = s_reg.por_n;
  assign regulator_en       = s_reg.reg_en;
  assign regulator_lowpower = s_reg.reg_lp;
  assign transceiver_en     = s_reg.xcvr_en;
  assign low_slew_en        = s_reg.slew_en;
  assign lin_dominant       = s_reg.lin_dom;
  assign uv_thresh_sel      = s_reg.otp.uv_sel;
  assign reset_out_n        = s_reg.rst_out_n;

endmodule : srw_top

// *** tb/srw_checker.sv ***
// Purpose: Port-level checks of the supervisor.
// Assumes: Straps held steady while the supply reset is high.
// Notes:   Counters measure how long a level has held.
`timescale 1ns/1ns
module srw_checker #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Inputs watched
  input wire logic              supply_above_release,
  input wire logic              supply_below_trip,
  input wire logic              rail_above_release,
  input wire logic              rail_below_trip,
  input wire logic              tx_n,
  input wire srw_pkg::srw_otp_t otp_strap,
  // Outputs watched
  input wire logic              supply_por_n,
  input wire logic              regulator_en,
  input wire logic              transceiver_en,
  input wire logic              lin_dominant,
  input wire logic [1:0]        uv_thresh_sel,
  input wire logic              reset_out_n
);
  import srw_pkg::*;
  // ------------------------------------------------------------------
  // Level timers
  // ------------------------------------------------------------------
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  logic [31:0] tx_cnt;
  logic [31:0] hold_cyc;
  assign hold_cyc = MS_CYCLES * (otp_strap.hold_sel == 2'h0 ? 8 :
                    otp_strap.hold_sel == 2'h1 ? 4 : otp_strap.hold_sel == 2'h2 ? 16 : 32);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      tx_cnt <= '0;
    end else begin
      hi_cnt <= rail_above_release ? hi_cnt + 1 : '0;
      lo_cnt <= rail_below_trip ? lo_cnt + 1 : '0;
      tx_cnt <= tx_n ? '0 : tx_cnt + 1;
    end
  end
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_por_rise; !supply_por_n && supply_above_release |=> supply_por_n; endproperty
  a_por_rise: assert property (p_por_rise) else $error("supply reset stuck");
  property p_por_fall; supply_por_n && supply_below_trip |=> !supply_por_n; endproperty
  a_por_fall: assert property (p_por_fall) else $error("supply reset missed");
  property p_por_off; !supply_por_n [*3] |-> !regulator_en && !transceiver_en; endproperty
  a_por_off: assert property (p_por_off) else $error("power on in reset");
  property p_por_up; $rose(supply_por_n) |-> ##[1:2] regulator_en && transceiver_en; endproperty
  a_por_up: assert property (p_por_up) else $error("no normal mode");
  property p_rail_hold; $rose(reset_out_n) |-> hi_cnt >= hold_cyc; endproperty
  a_rail_hold: assert property (p_rail_hold) else $error("reset released early");
  property p_glitch; reset_out_n && rail_below_trip && lo_cnt < 990 |=> reset_out_n; endproperty
  a_glitch: assert property (p_glitch) else $error("glitch caused reset");
  property p_trip; lo_cnt > 1010 |-> !reset_out_n; endproperty
  a_trip: assert property (p_trip) else $error("rail reset missed");
  property p_tx_rec; tx_n |=> !lin_dominant; endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("bus dominant");
  property p_tx_min; $fell(lin_dominant) && !tx_n && transceiver_en
    |-> tx_cnt >= 500 * MS_CYCLES; endproperty
  a_tx_min: assert property (p_tx_min) else $error("timeout early");
  property p_tx_max; tx_cnt > 2000 * MS_CYCLES |-> !lin_dominant; endproperty
  a_tx_max: assert property (p_tx_max) else $error("timeout late");
  property p_uv; supply_por_n && $past(supply_por_n, 2)
    |-> uv_thresh_sel == otp_strap.uv_sel; endproperty
  a_uv: assert property (p_uv) else $error("threshold select wrong");
  c_tx: cover property ($fell(lin_dominant));
  c_rst: cover property ($rose(reset_out_n));
  c_por: cover property ($fell(supply_por_n));
endmodule : srw_checker

bind srw_top srw_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .supply_above_release(supply_above_release),
  .supply_below_trip(supply_below_trip), .rail_above_release(rail_above_release),
  .rail_below_trip(rail_below_trip), .tx_n(tx_n), .otp_strap(otp_strap),
  .supply_por_n(supply_por_n), .regulator_en(regulator_en), .transceiver_en(transceiver_en),
  .lin_dominant(lin_dominant), .uv_thresh_sel(uv_thresh_sel), .reset_out_n(reset_out_n)
);

// *** tb/srw_mcu_model.sv ***
// Purpose: Microcontroller stand-in on the transmit line.
// Assumes: The bench commands a stuck-dominant fault.
// Notes:   A controller held in reset lets go of the line.
`timescale 1ns/1ns
module srw_mcu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bench command and reset pin
  input  wire logic stuck_dom,
  input  wire logic reset_out_n,
  // Transmit line
  output logic      tx_n
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_n <= 1'b1;
    end else begin
      tx_n <= ~(stuck_dom & reset_out_n);
    end
  end
endmodule : srw_mcu_model

// *** tb/tb.sv ***
// Purpose: Directed bench for the supervisor.
// Assumes: One millisecond is MS clock cycles.
// Notes:   Watchdog strap set only for the second supply start.
`timescale 1ns/1ns
module tb;
  import srw_pkg::*;
  localparam int MS = 10;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  logic        clk, rst, sup_ok, sup_trip, rail_ok, rail_trip;
  logic        t_shd, t_ret, t_warn, stuck, tx_n;
  logic        por_n, reg_en, reg_lp, xcvr_en, slew, lin_dom, rst_n;
  logic [1:0]  uv;
  logic [7:0]  q;
  srw_wb_req_t req;
  srw_wb_rsp_t rsp;
  srw_otp_t    otp;
  int          error_cnt = 0;
  int          tests_run = 0;
  srw_top #(.MS_CYCLES(MS)) DUT (
    .clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp),
    .supply_above_release(sup_ok), .supply_below_trip(sup_trip),
    .rail_above_release(rail_ok), .rail_below_trip(rail_trip),
    .temp_over_shutdown(t_shd), .temp_below_return(t_ret),
    .temp_over_warning(t_warn), .tx_n(tx_n), .wake_event(1'b0),
    .otp_strap(otp), .supply_por_n(por_n), .regulator_en(reg_en),
    .regulator_lowpower(reg_lp), .transceiver_en(xcvr_en),
    .low_slew_en(slew), .lin_dominant(lin_dom), .uv_thresh_sel(uv),
    .reset_out_n(rst_n)
  );
  srw_mcu_model u_mcu (
    .clk(clk), .rst(rst), .stuck_dom(stuck), .reset_out_n(rst_n), .tx_n(tx_n)
  );
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic chk1(input logic s, input logic e);
    chk({7'h0, s}, {7'h0, e});
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wait_for(input logic v, input int n);
    for (int k = 0; k < n && rst_n !== v; k++) @(posedge clk);
  endtask : wait_for
  // Holds the request until ack is sampled, then releases it
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1);
    q = rsp.dat[7:0];
    req <= '0;
    chk1(n == 2, 1'b1);
  endtask : wb
  task automatic end_sim;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_power;
    cyc(2);
    chk({6'h0, por_n, reg_en}, 8'h00);
    wb(1'b0, 8'h00, 8'h00);
    chk(q, 8'h08);
    wb(1'b0, 8'h10, 8'h00);
    chk(q, 8'h00);
    sup_ok <= 1'b1;
    cyc(4);
    chk({5'h0, por_n, reg_en, xcvr_en}, 8'h07);
    chk({6'h0, uv}, 8'h02);
    rail_ok <= 1'b1;
    cyc(7 * MS);
    chk1(rst_n, 1'b0);
    wait_for(1'b1, 5 * MS);
    chk1(rst_n, 1'b1);
  endtask : t_power
  task automatic t_tx;
    stuck <= 1'b1;
    cyc(3);
    chk1(lin_dom, 1'b1);
    cyc(495 * MS);
    chk1(lin_dom, 1'b1);
    cyc(1525 * MS);
    chk1(lin_dom, 1'b0);
    wb(1'b0, 8'h04, 8'h00);
    chk(q, 8'h02);
    stuck <= 1'b0;
    wb(1'b1, 8'h04, 8'h02);
  endtask : t_tx
  task automatic t_therm;
    t_warn <= 1'b1;
    wb(1'b0, 8'h04, 8'h00);
    chk(q, 8'h01);
    t_warn <= 1'b0;
    wb(1'b1, 8'h04, 8'h01);
    t_shd <= 1'b1;
    cyc(4);
    chk({5'h0, reg_en, xcvr_en, rst_n}, 8'h01);
    t_shd <= 1'b0;
    t_ret <= 1'b1;
    cyc(4);
    chk({6'h0, reg_en, xcvr_en}, 8'h03);
    t_ret <= 1'b0;
    wb(1'b1, 8'h00, 8'h00);
    t_shd <= 1'b1;
    cyc(4);
    chk1(reg_en, 1'b1);
    t_shd <= 1'b0;
    wb(1'b1, 8'h00, 8'h09);
    cyc(4);
    chk({6'h0, reg_en, rst_n}, 8'h01);
    cyc(130 * MS);
    wb(1'b0, 8'h00, 8'h00);
    chk({reg_en, q[6:0]}, 8'h88);
  endtask : t_therm
  task automatic t_supply;
    wb(1'b1, 8'h00, 8'h0a);
    sup_ok <= 1'b0;
    cyc(8);
    chk({6'h0, por_n, reg_lp}, 8'h03);
    sup_ok <= 1'b1;
    wb(1'b1, 8'h00, 8'h0c);
    cyc(4);
    chk1(slew, 1'b1);
    sup_ok <= 1'b0;
    sup_trip <= 1'b1;
    cyc(4);
    chk({4'h0, por_n, reg_en, xcvr_en, slew}, 8'h00);
    wb(1'b0, 8'h00, 8'h00);
    chk(q, 8'h08);
    otp.wd_enable <= 1'b1;
    sup_trip <= 1'b0;
    sup_ok <= 1'b1;
    cyc(4);
    chk({5'h0, por_n, reg_en, slew}, 8'h06);
  endtask : t_supply
  task automatic t_wd;
    int n;
    wait_for(1'b1, 20 * MS);
    cyc(150 * MS);
    wb(1'b1, 8'h0c, 8'h01);
    cyc(150 * MS);
    chk1(rst_n, 1'b1);
    wb(1'b1, 8'h0c, 8'h01);
    cyc(50 * MS);
    wb(1'b1, 8'h0c, 8'h01);
    wait_for(1'b0, 2 * MS);
    chk1(rst_n, 1'b0);
    for (n = 0; n < 20 * MS && rst_n !== 1'b1; n++) @(posedge clk);
    chk1(n >= 7 * MS && n <= 10 * MS, 1'b1);
    wb(1'b0, 8'h04, 8'h00);
    chk(q, 8'h04);
    wb(1'b1, 8'h04, 8'h04);
    cyc(190 * MS);
    chk1(rst_n, 1'b1);
    wait_for(1'b0, 20 * MS);
    chk1(rst_n, 1'b0);
    wait_for(1'b1, 15 * MS);
    rail_ok <= 1'b0;
    rail_trip <= 1'b1;
    cyc(500);
    chk1(rst_n, 1'b1);
    cyc(600);
    chk1(rst_n, 1'b0);
  endtask : t_wd
  // ------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {sup_ok, sup_trip, rail_ok, rail_trip, t_shd, t_ret, t_warn, stuck} = '0;
    req = '0;
    otp = '{1'b0, 3'h0, 2'h0, 2'h2};
    cyc(16);
    rst <= 1'b0;
    t_power();
    t_tx();
    t_therm();
    t_supply();
    t_wd();
    end_sim();
  end
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule : tb
